// *** src/mtp_regs.svh ***
// register offsets, field positions, reset values and timing counts of the timer set
`ifndef MTP_REGS_SVH
`define MTP_REGS_SVH
`define MTP_ADDR_TCTL   8'h88
`define MTP_ADDR_TMODE  8'h89
`define MTP_ADDR_TL0    8'h8A
`define MTP_ADDR_TL1    8'h8B
`define MTP_ADDR_TH0    8'h8C
`define MTP_ADDR_TH1    8'h8D
`define MTP_ADDR_XFLAG  8'h91
`define MTP_ADDR_PBCTL  8'hA9
`define MTP_ADDR_TH2    8'hAA
`define MTP_ADDR_TH3    8'hAB
`define MTP_ADDR_TL2    8'hAC
`define MTP_ADDR_TL3    8'hAD
`define MTP_RST_BYTE    8'h00
// timer_control fields
`define MTP_B_OVF1      7
`define MTP_B_RUN1      6
`define MTP_B_OVF0      5
`define MTP_B_RUN0      4
`define MTP_B_XF1       3
`define MTP_B_XT1       2
`define MTP_B_XF0       1
`define MTP_B_XT0       0
// timer_mode_control fields
`define MTP_B_PIN_GATING_ONE     7
`define MTP_B_CSEL1     6
`define MTP_F_MODE1     5:4
`define MTP_B_PIN_GATING_ZERO     3
`define MTP_B_CSEL0     2
`define MTP_F_MODE0     1:0
// pair b control and extended flag fields
`define MTP_B_RUN3      3
`define MTP_B_PULSE_OUT_THREE      2
`define MTP_B_RUN2      1
`define MTP_B_PULSE_OUT_TWO      0
`define MTP_B_TO3       7
`define MTP_B_TO2       5
// timing
`define MTP_CLK_HZ      40000000
`define MTP_DIV_TICK    12
`define MTP_PRE_T2      8
`define MTP_PRE_T3      3
`define MTP_PWM_STEPS   256
`define MTP_FIX0_HZ     15625
`define MTP_FIX1_HZ     7812
`define MTP_FIX0_DIV    (`MTP_CLK_HZ / (`MTP_PWM_STEPS * `MTP_FIX0_HZ))
`define MTP_FIX1_DIV    (`MTP_CLK_HZ / (`MTP_PWM_STEPS * `MTP_FIX1_HZ))
`endif

// *** src/mtp_pkg.sv ***
// types shared by the timer set
package mtp_pkg;
  typedef enum logic [1:0] {
    MTP_M12,
    MTP_M16,
    MTP_M8R,
    MTP_SPLIT
  } mtp_mode_e;
  typedef logic [7:0] mtp_byte_t;
endpackage

// *** src/mtp_timers.sv ***
// timer zero/one, timer two/three with pwm, and their special-function registers
`timescale 1ns/1ps
`include "mtp_regs.svh"
module mtp_timers #(
  parameter int DIV_TICK = `MTP_DIV_TICK,
  parameter int PRE_T2   = `MTP_PRE_T2,
  parameter int PRE_T3   = `MTP_PRE_T3
) (
  // clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rstn,
  // special-function register port
  input  wire logic [7:0]        i_sfr_addr,
  input  wire logic              i_sfr_wr_en,
  input  wire mtp_pkg::mtp_byte_t i_sfr_wdata,
  output logic      [7:0]        o_sfr_rdata,
  // service routine entry acknowledges
  input  wire logic              i_ack_ovf_zero,
  input  wire logic              i_ack_ovf_one,
  input  wire logic              i_ack_ext_zero,
  input  wire logic              i_ack_ext_one,
  input  wire logic              i_ack_to_two,
  input  wire logic              i_ack_to_three,
  // external pins
  input  wire logic              i_count_input_zero,
  input  wire logic              i_count_input_one,
  input  wire logic              i_ext_irq_pin_zero,
  input  wire logic              i_ext_irq_pin_one,
  // interrupt requests
  output logic                   o_overflow_flag_zero,
  output logic                   o_overflow_flag_one,
  output logic                   o_ext_irq_flag_zero,
  output logic                   o_ext_irq_flag_one,
  output logic                   o_timeout_pending_two,
  output logic                   o_timeout_pending_three,
  // pwm port pins
  output logic                   o_pulse_out_two,
  output logic                   o_pulse_out_three
);
  import mtp_pkg::*;

  localparam int FIX0_DIV = `MTP_FIX0_DIV;
  localparam int FIX1_DIV = `MTP_FIX1_DIV;

  // refuse settings the counters cannot hold
  // checked at elaboration, so a bad setting never reaches a run
  if (DIV_TICK < 2 || DIV_TICK > 15 || PRE_T2 < 1 || PRE_T2 > 255 || PRE_T3 < 1 || PRE_T3 > 255) begin
    $error("mtp_timers: prescale parameter out of range");
  end

  // state
  logic [3:0]  div_q, div_d;               // twelve-clock divider
  logic        tick_q, tick_d;             // one-cycle pulse per division
  logic [1:0]  smp_q, smp_d;               // latest count pin samples
  logic [1:0]  smp_old_q, smp_old_d;       // previous count pin samples
  logic [1:0]  pin_old_q, pin_old_d;       // ext pins last clock, for edges
  mtp_byte_t   tctl_q, tctl_d;             // timer_control
  mtp_byte_t   tmode_q, tmode_d;           // timer_mode_control
  mtp_byte_t   tl0_q, tl0_d, th0_q, th0_d;
  mtp_byte_t   tl1_q, tl1_d, th1_q, th1_d;
  mtp_byte_t   pbctl_q, pbctl_d;           // timer_pair_b_control
  mtp_byte_t   th_q [2], th_d [2];         // index 0 timer two, 1 timer three
  mtp_byte_t   tl_q [2], tl_d [2];
  logic [8:0]  pre_q [2], pre_d [2];       // prescale / pwm step divider
  logic [15:0] cnt_q [2], cnt_d [2];       // hidden up counter, low byte is pwm phase
  logic [1:0]  to_q, to_d;                 // timeout pending flags
  logic [1:0]  pwm_q, pwm_d;               // pwm pins
  mtp_byte_t   rdata_q, rdata_d;

  // one step of a classic timer: {overflow, high, low}
  function automatic logic [16:0] mtp_step(input mtp_mode_e m, input mtp_byte_t th, input mtp_byte_t tl);
    logic [11:0] c12;
    logic [16:0] r;
    c12 = {th[6:0], tl[4:0]} + 12'h001;
    r   = {1'b0, th, tl};
    case (m)
      MTP_M12: begin
        // upper bits of both bytes left alone
        r = {({th[6:0], tl[4:0]} == 12'hFFF), th[7], c12[11:5], tl[7:5], c12[4:0]};
      end
      MTP_M16: begin
        r = {1'b0, th, tl} + 17'h00001;
      end
      MTP_M8R: begin
        r = (tl == 8'hFF) ? {1'b1, th, th} : {1'b0, th, tl + 8'h01};
      end
      MTP_SPLIT: begin
        r = {(tl == 8'hFF), th, tl + 8'h01};
      end
      default: begin
        r = {1'b0, th, tl};
      end
    endcase
    return r;
  endfunction

  // one clock of timer two/three: {event, pwm level, pre, cnt}
  function automatic logic [26:0] mtp_pair(input logic run, input logic pwm, input logic [8:0] pmax_t,
                                           input logic [8:0] pre, input logic [15:0] cnt,
                                           input mtp_byte_t th, input mtp_byte_t tl);
    logic [8:0]  pmax;
    logic [7:0]  ph;
    logic        evt;
    logic [8:0]  p;
    logic [15:0] c;
    pmax = pmax_t;
    ph   = cnt[7:0];
    evt  = 1'b0;
    p    = pre;
    c    = cnt;
    if (!run) begin
      p = 9'h000;
      c = 16'h0000;
    end else if (pwm) begin
      // step length th+1 clocks, except the two fixed-rate codes
      if (th == 8'h00) begin
        pmax = 9'(FIX0_DIV - 1);
      end else if (th == 8'h01) begin
        pmax = 9'(FIX1_DIV - 1);
      end else begin
        pmax = {1'b0, th};
      end
      if (pre >= pmax) begin
        p  = 9'h000;
        ph = cnt[7:0] + 8'h01;
        c  = {8'h00, ph};
      end else begin
        p = pre + 9'h001;
      end
    end else begin
      if (pre >= pmax) begin
        p = 9'h000;
        if (cnt >= {th, tl}) begin
          c   = 16'h0000;
          evt = 1'b1;
        end else begin
          c = cnt + 16'h0001;
        end
      end else begin
        p = pre + 9'h001;
      end
    end
    // high while phase below the duty byte
    return {evt, run & pwm & (ph < tl), p, c};
  endfunction

  // next-state logic for the whole block
  always_comb begin
    logic        en0, en1, en0h, fall0, fall1;
    logic [16:0] s0, s0h, s1;
    logic [26:0] pr;
    mtp_mode_e   m0, m1;
    en0 = 1'b0; en1 = 1'b0; en0h = 1'b0; fall0 = 1'b0; fall1 = 1'b0;
    s0 = 17'h00000; s0h = 17'h00000; s1 = 17'h00000; pr = 27'h0000000;
    m0 = mtp_mode_e'(tmode_q[`MTP_F_MODE0]);
    m1 = mtp_mode_e'(tmode_q[`MTP_F_MODE1]);
    div_d = div_q; tick_d = 1'b0; smp_d = smp_q; smp_old_d = smp_old_q;
    pin_old_d = {i_ext_irq_pin_one, i_ext_irq_pin_zero};
    tctl_d = tctl_q; tmode_d = tmode_q; pbctl_d = pbctl_q;
    tl0_d = tl0_q; th0_d = th0_q; tl1_d = tl1_q; th1_d = th1_q;
    to_d = to_q; pwm_d = pwm_q;
    for (int i = 0; i < 2; i++) begin
      th_d[i] = th_q[i]; tl_d[i] = tl_q[i]; pre_d[i] = pre_q[i]; cnt_d[i] = cnt_q[i];
    end

    // divide the clock by twelve into a tick pulse
    if (div_q == 4'(DIV_TICK - 1)) begin
      div_d  = 4'h0;
      tick_d = 1'b1;
    end else begin
      div_d = div_q + 4'h1;
    end

    // count pins sampled on each tick, falls seen across two samples
    if (tick_q) begin
      smp_old_d = smp_q;
      smp_d     = {i_count_input_one, i_count_input_zero};
      fall0     = smp_old_q[0] & ~smp_q[0];
      fall1     = smp_old_q[1] & ~smp_q[1];
    end

    // enables: run, gate by pin, tick or pin event
    en0 = tctl_q[`MTP_B_RUN0] & (~tmode_q[`MTP_B_PIN_GATING_ZERO] | i_ext_irq_pin_zero)
          & (tmode_q[`MTP_B_CSEL0] ? fall0 : tick_q);
    en1 = tctl_q[`MTP_B_RUN1] & (~tmode_q[`MTP_B_PIN_GATING_ONE] | i_ext_irq_pin_one)
          & (tmode_q[`MTP_B_CSEL1] ? fall1 : tick_q);
    en0h = (m0 == MTP_SPLIT) & tctl_q[`MTP_B_RUN1] & tick_q;

    // timer zero, both halves in split mode
    s0 = mtp_step(m0, th0_q, tl0_q);
    if (en0) begin
      tl0_d = s0[7:0];
      if (m0 != MTP_SPLIT) begin
        th0_d = s0[15:8];
      end
      if (s0[16]) begin
        tctl_d[`MTP_B_OVF0] = 1'b1;
      end
    end
    s0h = mtp_step(MTP_SPLIT, 8'h00, th0_q);
    if (en0h) begin
      th0_d = s0h[7:0];
      if (s0h[16]) begin
        tctl_d[`MTP_B_OVF1] = 1'b1;
      end
    end

    // timer one stands still while timer zero is split
    s1 = mtp_step(m1, th1_q, tl1_q);
    if (en1 && m0 != MTP_SPLIT && m1 != MTP_SPLIT) begin
      tl1_d = s1[7:0];
      th1_d = s1[15:8];
      if (s1[16]) begin
        tctl_d[`MTP_B_OVF1] = 1'b1;
      end
    end

    // external interrupt flags: edge latches, level follows the inverted pin
    if (tctl_q[`MTP_B_XT0]) begin
      if (pin_old_q[0] & ~i_ext_irq_pin_zero) tctl_d[`MTP_B_XF0] = 1'b1;
    end else begin
      tctl_d[`MTP_B_XF0] = ~i_ext_irq_pin_zero;
    end
    if (tctl_q[`MTP_B_XT1]) begin
      if (pin_old_q[1] & ~i_ext_irq_pin_one) tctl_d[`MTP_B_XF1] = 1'b1;
    end else begin
      tctl_d[`MTP_B_XF1] = ~i_ext_irq_pin_one;
    end

    // timer two and three, timer or pwm
    for (int i = 0; i < 2; i++) begin
      pr = mtp_pair((i == 0) ? pbctl_q[`MTP_B_RUN2] : pbctl_q[`MTP_B_RUN3],
                    (i == 0) ? pbctl_q[`MTP_B_PULSE_OUT_TWO] : pbctl_q[`MTP_B_PULSE_OUT_THREE],
                    (i == 0) ? 9'(PRE_T2 - 1) : 9'(PRE_T3 - 1),
                    pre_q[i], cnt_q[i], th_q[i], tl_q[i]);
      pre_d[i] = pr[24:16];
      cnt_d[i] = pr[15:0];
      pwm_d[i] = pr[25];
      if (pr[26]) begin
        to_d[i] = 1'b1;
      end
    end

    // software writes replace the byte; flags set by hardware still win
    if (i_sfr_wr_en) begin
      case (i_sfr_addr)
        `MTP_ADDR_TCTL:  tctl_d  = i_sfr_wdata | (tctl_d & tctl_q & 8'h00) | (tctl_d & ~tctl_q & 8'hAA);
        `MTP_ADDR_TMODE: tmode_d = i_sfr_wdata;
        `MTP_ADDR_TL0:   tl0_d   = i_sfr_wdata;
        `MTP_ADDR_TH0:   th0_d   = i_sfr_wdata;
        `MTP_ADDR_TL1:   tl1_d   = i_sfr_wdata;
        `MTP_ADDR_TH1:   th1_d   = i_sfr_wdata;
        `MTP_ADDR_PBCTL: pbctl_d = i_sfr_wdata;
        `MTP_ADDR_TH2:   th_d[0] = i_sfr_wdata;
        `MTP_ADDR_TH3:   th_d[1] = i_sfr_wdata;
        `MTP_ADDR_TL2:   tl_d[0] = i_sfr_wdata;
        `MTP_ADDR_TL3:   tl_d[1] = i_sfr_wdata;
        `MTP_ADDR_XFLAG: to_d    = {i_sfr_wdata[`MTP_B_TO3], i_sfr_wdata[`MTP_B_TO2]} | (to_d & ~to_q);
        default: begin
        end
      endcase
    end

    // service routine entry clears a flag unless set again this cycle, an overflow flag unless it rises this cycle; external flags only under edge trigger
    if (i_ack_ovf_zero && !(tctl_d[`MTP_B_OVF0] && !tctl_q[`MTP_B_OVF0])) tctl_d[`MTP_B_OVF0] = 1'b0;
    if (i_ack_ovf_one && !(tctl_d[`MTP_B_OVF1] && !tctl_q[`MTP_B_OVF1])) tctl_d[`MTP_B_OVF1] = 1'b0;
    if (i_ack_ext_zero && tctl_q[`MTP_B_XT0] && !(pin_old_q[0] & ~i_ext_irq_pin_zero)) begin
      tctl_d[`MTP_B_XF0] = 1'b0;
    end
    if (i_ack_ext_one && tctl_q[`MTP_B_XT1] && !(pin_old_q[1] & ~i_ext_irq_pin_one)) begin
      tctl_d[`MTP_B_XF1] = 1'b0;
    end
    if (i_ack_to_two && !pr_evt(0)) to_d[0] = 1'b0;
    if (i_ack_to_three && !pr_evt(1)) to_d[1] = 1'b0;

    // read data registered, unmapped reads zero
    case (i_sfr_addr)
      `MTP_ADDR_TCTL:  rdata_d = tctl_q;
      `MTP_ADDR_TMODE: rdata_d = tmode_q;
      `MTP_ADDR_TL0:   rdata_d = tl0_q;
      `MTP_ADDR_TH0:   rdata_d = th0_q;
      `MTP_ADDR_TL1:   rdata_d = tl1_q;
      `MTP_ADDR_TH1:   rdata_d = th1_q;
      `MTP_ADDR_PBCTL: rdata_d = pbctl_q;
      `MTP_ADDR_TH2:   rdata_d = th_q[0];
      `MTP_ADDR_TH3:   rdata_d = th_q[1];
      `MTP_ADDR_TL2:   rdata_d = tl_q[0];
      `MTP_ADDR_TL3:   rdata_d = tl_q[1];
      `MTP_ADDR_XFLAG: rdata_d = {to_q[1], 1'b0, to_q[0], 5'h00};
      default:         rdata_d = 8'h00;
    endcase
  end

  // a timeout happening now; used so an ack cannot swallow it
  function automatic logic pr_evt(input int i);
    logic [26:0] r;
    r = mtp_pair((i == 0) ? pbctl_q[`MTP_B_RUN2] : pbctl_q[`MTP_B_RUN3],
                 (i == 0) ? pbctl_q[`MTP_B_PULSE_OUT_TWO] : pbctl_q[`MTP_B_PULSE_OUT_THREE],
                 (i == 0) ? 9'(PRE_T2 - 1) : 9'(PRE_T3 - 1),
                 pre_q[i], cnt_q[i], th_q[i], tl_q[i]);
    return r[26];
  endfunction

  // registers only
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      div_q <= 4'h0; tick_q <= 1'b0; smp_q <= 2'b00; smp_old_q <= 2'b00; pin_old_q <= 2'b11;
      tctl_q <= `MTP_RST_BYTE; tmode_q <= `MTP_RST_BYTE; pbctl_q <= `MTP_RST_BYTE;
      tl0_q <= `MTP_RST_BYTE; th0_q <= `MTP_RST_BYTE; tl1_q <= `MTP_RST_BYTE; th1_q <= `MTP_RST_BYTE;
      to_q <= 2'b00; pwm_q <= 2'b00; rdata_q <= 8'h00;
      for (int i = 0; i < 2; i++) begin
        th_q[i] <= `MTP_RST_BYTE; tl_q[i] <= `MTP_RST_BYTE; pre_q[i] <= 9'h000; cnt_q[i] <= 16'h0000;
      end
    end else begin
      div_q <= div_d; tick_q <= tick_d; smp_q <= smp_d; smp_old_q <= smp_old_d; pin_old_q <= pin_old_d;
      tctl_q <= tctl_d; tmode_q <= tmode_d; pbctl_q <= pbctl_d;
      tl0_q <= tl0_d; th0_q <= th0_d; tl1_q <= tl1_d; th1_q <= th1_d;
      to_q <= to_d; pwm_q <= pwm_d; rdata_q <= rdata_d;
      for (int i = 0; i < 2; i++) begin
        th_q[i] <= th_d[i]; tl_q[i] <= tl_d[i]; pre_q[i] <= pre_d[i]; cnt_q[i] <= cnt_d[i];
      end
    end
  end

  // outputs straight from flops
  assign o_sfr_rdata             = rdata_q;
  assign o_overflow_flag_zero    = tctl_q[`MTP_B_OVF0];
  assign o_overflow_flag_one     = tctl_q[`MTP_B_OVF1];
  assign o_ext_irq_flag_zero     = tctl_q[`MTP_B_XF0];
  assign o_ext_irq_flag_one      = tctl_q[`MTP_B_XF1];
  assign o_timeout_pending_two   = to_q[0];
  assign o_timeout_pending_three = to_q[1];
  assign o_pulse_out_two         = pwm_q[0];
  assign o_pulse_out_three       = pwm_q[1];
endmodule

// *** test/mtp_timers_monitor.sv ***
// port-level checker for the timer set
`timescale 1ns/1ps
`include "mtp_regs.svh"
module mtp_timers_monitor #(
  parameter int DIV_TICK = 12,
  parameter int PRE_T2   = 8,
  parameter int PRE_T3   = 3
) (
  // clock, reset, register port
  input wire logic               i_ref_clk,
  input wire logic               i_rstn,
  input wire logic [7:0]         i_sfr_addr,
  input wire logic               i_sfr_wr_en,
  input wire mtp_pkg::mtp_byte_t i_sfr_wdata,
  input wire logic [7:0]         o_sfr_rdata,
  // acks, pins, flags
  input wire logic               i_ack_ovf_zero,
  input wire logic               i_ack_ovf_one,
  input wire logic               i_ack_to_two,
  input wire logic               i_ack_to_three,
  input wire logic               i_ext_irq_pin_zero,
  input wire logic               i_ext_irq_pin_one,
  input wire logic               o_overflow_flag_zero,
  input wire logic               o_overflow_flag_one,
  input wire logic               o_ext_irq_flag_zero,
  input wire logic               o_ext_irq_flag_one,
  input wire logic               o_timeout_pending_two,
  input wire logic               o_timeout_pending_three
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // write then read of a byte no hardware touches
  sequence s_wr_th2;
    i_sfr_wr_en && i_sfr_addr == `MTP_ADDR_TH2 ##1 i_sfr_addr == `MTP_ADDR_TH2 && !i_sfr_wr_en;
  endsequence
  a_th2_read_back: assert property (s_wr_th2 |=> o_sfr_rdata == $past(i_sfr_wdata, 2))
    else $error("read after write of timer two high byte differs");
  a_unmapped_reads_zero: assert property (i_sfr_addr == 8'h90 |=> o_sfr_rdata == 8'h00)
    else $error("unmapped address read not zero");
  // ack clears a flag unless software writes meanwhile or, for a timeout pending flag, a new timeout lands in the same cycle
  a_ovf0_ack_clear: assert property (o_overflow_flag_zero && i_ack_ovf_zero && !i_sfr_wr_en |=> !o_overflow_flag_zero)
    else $error("timer zero flag survived ack");
  a_ovf1_ack_clear: assert property (o_overflow_flag_one && i_ack_ovf_one && !i_sfr_wr_en |=> !o_overflow_flag_one)
    else $error("timer one flag survived ack");
  a_to2_ack_clear: assert property (o_timeout_pending_two && i_ack_to_two && !i_sfr_wr_en |=> !o_timeout_pending_two)
    else $error("timer two pending survived ack");
  a_to3_ack_clear: assert property (o_timeout_pending_three && i_ack_to_three && !i_sfr_wr_en |=> !o_timeout_pending_three)
    else $error("timer three pending survived ack");
  // a fall sets the flag in either trigger type
  a_ext0_fall_flag: assert property ($fell(i_ext_irq_pin_zero) && !i_sfr_wr_en |=> o_ext_irq_flag_zero)
    else $error("pin zero fall did not set flag");
  a_ext1_fall_flag: assert property ($fell(i_ext_irq_pin_one) && !i_sfr_wr_en |=> o_ext_irq_flag_one)
    else $error("pin one fall did not set flag");
  // a flag only rises after a low pin or a write
  a_ext0_rise_cause: assert property ($rose(o_ext_irq_flag_zero) |-> !$past(i_ext_irq_pin_zero) || $past(i_sfr_wr_en))
    else $error("flag zero rose without cause");
  a_ext1_rise_cause: assert property ($rose(o_ext_irq_flag_one) |-> !$past(i_ext_irq_pin_one) || $past(i_sfr_wr_en))
    else $error("flag one rose without cause");
  c_ovf_one: cover property (o_overflow_flag_one);
  c_to3_ack: cover property (o_timeout_pending_three && i_ack_to_three);
  c_ext1_edge: cover property ($fell(i_ext_irq_pin_one) ##1 o_ext_irq_flag_one);
endmodule
bind mtp_timers mtp_timers_monitor #(.DIV_TICK(DIV_TICK), .PRE_T2(PRE_T2), .PRE_T3(PRE_T3)) u_mon (
  .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr_en(i_sfr_wr_en),
  .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_ack_ovf_zero(i_ack_ovf_zero),
  .i_ack_ovf_one(i_ack_ovf_one), .i_ack_to_two(i_ack_to_two), .i_ack_to_three(i_ack_to_three),
  .i_ext_irq_pin_zero(i_ext_irq_pin_zero), .i_ext_irq_pin_one(i_ext_irq_pin_one),
  .o_overflow_flag_zero(o_overflow_flag_zero), .o_overflow_flag_one(o_overflow_flag_one),
  .o_ext_irq_flag_zero(o_ext_irq_flag_zero), .o_ext_irq_flag_one(o_ext_irq_flag_one),
  .o_timeout_pending_two(o_timeout_pending_two), .o_timeout_pending_three(o_timeout_pending_three));

// *** test/mtp_pins_model.sv ***
// behavioural drive of the external count pins
`timescale 1ns/1ps
module mtp_pins_model #(
  parameter int HI_ONE = 26, // short high, long low
  parameter int LO_ONE = 40
) (
  // clock and enable
  input  wire logic i_ref_clk,
  input  wire logic i_en,
  // count pins
  output logic      o_count_input_zero,
  output logic      o_count_input_one
);
  int ph = 0; // phase within one wave
  // pins idle high
  initial {o_count_input_zero, o_count_input_one} = 2'b11;
  // one fall per wave, uneven duty, each level longer than one sample
  always @(posedge i_ref_clk) begin
    ph <= (i_en && ph < HI_ONE + LO_ONE - 1) ? ph + 1 : 0;
    o_count_input_one  <= !(i_en && ph >= HI_ONE);
    o_count_input_zero <= !(i_en && ph >= 2 * HI_ONE);
  end
endmodule

// *** test/mtp_timers_test.sv ***
// self-checking bench for the timer set
`timescale 1ns/1ps
`include "mtp_regs.svh"
module mtp_timers_test;
  import mtp_pkg::*;
  localparam int D = `MTP_DIV_TICK;
  // drivers
  logic       i_ref_clk   = 1'b0;
  logic       i_rstn      = 1'b0;
  logic [7:0] i_sfr_addr  = 8'h00;
  logic       i_sfr_wr_en = 1'b0;
  mtp_byte_t  i_sfr_wdata = 8'h00;
  logic [5:0] ack         = 6'h00; // ovf0 ovf1 ext0 ext1 to2 to3
  logic [1:0] irq_pin     = 2'b11; // idle high
  logic       cnt_en      = 1'b0;
  wire  [7:0] o_sfr_rdata;
  wire  [1:0] cnt_pin;
  wire  [7:0] outs; // pulse_out_three pulse_out_two to3 to2 ext1 ext0 ovf1 ovf0
  int         failures    = 0;
  int         n_compared  = 0;
  int         cyc         = 0;
  int         rt[8], gap[8], hi[8]; // rise time, rise spacing, high width
  logic [7:0] prev        = 8'h00;
  // register rows: address, write data, read expectation
  logic [23:0] rows[13] = '{24'h895A5A, 24'h8A5555, 24'h8BAAAA, 24'h8C3C3C, 24'h8DC3C3, 24'hAA1212,
    24'hAB3434, 24'hAC5656, 24'hAD7878, 24'hA90505, 24'h91FFA0, 24'h90FF00, 24'h880505};
  mtp_timers DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr), .i_sfr_wr_en(i_sfr_wr_en),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_ack_ovf_zero(ack[0]), .i_ack_ovf_one(ack[1]),
    .i_ack_ext_zero(ack[2]), .i_ack_ext_one(ack[3]), .i_ack_to_two(ack[4]), .i_ack_to_three(ack[5]),
    .i_count_input_zero(cnt_pin[0]), .i_count_input_one(cnt_pin[1]), .i_ext_irq_pin_zero(irq_pin[0]),
    .i_ext_irq_pin_one(irq_pin[1]), .o_overflow_flag_zero(outs[0]), .o_overflow_flag_one(outs[1]),
    .o_ext_irq_flag_zero(outs[2]), .o_ext_irq_flag_one(outs[3]), .o_timeout_pending_two(outs[4]),
    .o_timeout_pending_three(outs[5]), .o_pulse_out_two(outs[6]), .o_pulse_out_three(outs[7]));
  mtp_pins_model u_pins (.i_ref_clk(i_ref_clk), .i_en(cnt_en), .o_count_input_zero(cnt_pin[0]),
    .o_count_input_one(cnt_pin[1]));
  // 40 MHz clock
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  // edge timing of every output, sampled before the edge updates land
  always @(posedge i_ref_clk) begin
    for (int b = 0; b < 8; b++) begin
      if (outs[b] === 1'b1 && prev[b] === 1'b0) begin
        gap[b] = cyc - rt[b];
        rt[b] = cyc;
      end
      if (outs[b] === 1'b0 && prev[b] === 1'b1) hi[b] = cyc - rt[b];
    end
    prev = outs;
    cyc++;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // cycle counts against a window
  task automatic chkn(input int got, input int lo, input int up);
    n_compared++;
    if (got < lo || got > up) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, up);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_wr_en <= 1'b1;
    @(posedge i_ref_clk);
    i_sfr_wr_en <= 1'b0;
  endtask
  // read data is registered, one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_sfr_addr <= a;
    @(posedge i_ref_clk);
    #1 d = o_sfr_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk8(v, e);
  endtask
  task automatic ackp(input int i);
    @(posedge i_ref_clk);
    ack[i] <= 1'b1;
    @(posedge i_ref_clk);
    ack[i] <= 1'b0;
    // step past the edge so callers see the cleared flag, not its old value
    #1;
  endtask
  // bounded wait for an output level
  task automatic wt(input int b, input int lim, output int n);
    n = 0;
    while (outs[b] !== 1'b1 && n < lim) begin
      @(posedge i_ref_clk);
      #1 n++;
    end
  endtask
  task automatic stop_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog, well past the expected run
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
  initial begin
    logic [7:0] v;
    int n;
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    foreach (rows[i]) rdchk(rows[i][23:16], 8'h00);
    chk8(outs, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0]);
    end
    foreach (rows[i]) wr(rows[i][23:16], 8'h00);
    // sixteen bit wrap, then ack
    wr(`MTP_ADDR_TMODE, 8'h01); wr(`MTP_ADDR_TH0, 8'hFF); wr(`MTP_ADDR_TL0, 8'hFE); wr(`MTP_ADDR_TCTL, 8'h10);
    wt(0, 2 * D + 4, n);
    chkn(n, D, 2 * D + 3);
    wr(`MTP_ADDR_TCTL, 8'h20);
    ackp(0);
    chk8(outs, 8'h00);
    rdchk(`MTP_ADDR_TL0, 8'h00);
    // twelve bit: ignored upper bits kept
    wr(`MTP_ADDR_TMODE, 8'h00); wr(`MTP_ADDR_TL0, 8'hFF); wr(`MTP_ADDR_TH0, 8'hFF); wr(`MTP_ADDR_TCTL, 8'h10);
    wt(0, D + 3, n);
    chkn(n, 0, D + 2);
    wr(`MTP_ADDR_TCTL, 8'h00);
    rdchk(`MTP_ADDR_TL0, 8'hE0);
    rdchk(`MTP_ADDR_TH0, 8'h80);
    // auto-reload
    wr(`MTP_ADDR_TMODE, 8'h02); wr(`MTP_ADDR_TH0, 8'hF0); wr(`MTP_ADDR_TL0, 8'hFF); wr(`MTP_ADDR_TCTL, 8'h10);
    wt(0, D + 3, n);
    wr(`MTP_ADDR_TCTL, 8'h00);
    rdchk(`MTP_ADDR_TL0, 8'hF0);
    rdchk(`MTP_ADDR_TH0, 8'hF0);
    // event counting on pin one: no ticks counted while the pin idles
    wr(`MTP_ADDR_TMODE, 8'h50); wr(`MTP_ADDR_TH1, 8'hFF); wr(`MTP_ADDR_TL1, 8'hFD); wr(`MTP_ADDR_TCTL, 8'h40);
    repeat (60) @(posedge i_ref_clk);
    rdchk(`MTP_ADDR_TL1, 8'hFD);
    cnt_en <= 1'b1;
    wt(1, 220, n);
    chkn(n, 150, 219);
    wr(`MTP_ADDR_TCTL, 8'h00);
    cnt_en <= 1'b0;
    rdchk(`MTP_ADDR_TL1, 8'h00);
    // gating by pin zero, level trigger
    wr(`MTP_ADDR_TMODE, 8'h09); wr(`MTP_ADDR_TL0, 8'h00); wr(`MTP_ADDR_TH0, 8'h00);
    irq_pin[0] <= 1'b0;
    wr(`MTP_ADDR_TCTL, 8'h10);
    repeat (100) @(posedge i_ref_clk);
    rdchk(`MTP_ADDR_TL0, 8'h00);
    chk8(outs, 8'h04);
    irq_pin[0] <= 1'b1;
    repeat (120) @(posedge i_ref_clk);
    #1 chk8(outs, 8'h00);
    wr(`MTP_ADDR_TCTL, 8'h00);
    rd(`MTP_ADDR_TL0, v);
    chkn(v, 120 / D - 1, 120 / D + 1);
    // edge trigger: ack holds while pin stays low
    for (int i = 0; i < 2; i++) begin
      wr(`MTP_ADDR_TCTL, i ? 8'h04 : 8'h01);
      irq_pin[i] <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      #1 chk8(outs, i ? 8'h08 : 8'h04);
      ackp(2 + i);
      repeat (5) @(posedge i_ref_clk);
      #1 chk8(outs, 8'h00);
      irq_pin[i] <= 1'b1;
    end
    wr(`MTP_ADDR_TCTL, 8'h00);
    // split mode: high byte of timer zero under run bit one
    wr(`MTP_ADDR_TL0, 8'h22);
    wr(`MTP_ADDR_TL1, 8'h11); wr(`MTP_ADDR_TMODE, 8'h03); wr(`MTP_ADDR_TH0, 8'hFF); wr(`MTP_ADDR_TCTL, 8'h40);
    wt(1, D + 3, n);
    chkn(n, 0, D + 2);
    wr(`MTP_ADDR_TCTL, 8'h80);
    ackp(1);
    chk8(outs, 8'h00);
    rdchk(`MTP_ADDR_TL1, 8'h11);
    rdchk(`MTP_ADDR_TL0, 8'h22);
    // timeout spacing of timers two and three
    for (int t = 0; t < 2; t++) begin
      // timer two kept just above the shortest advised period, about 100.2 us
      wr(t ? `MTP_ADDR_TH3 : `MTP_ADDR_TH2, t ? 8'h00 : 8'h01);
      wr(t ? `MTP_ADDR_TL3 : `MTP_ADDR_TL2, t ? 8'h09 : 8'hF4);
      wr(`MTP_ADDR_PBCTL, t ? 8'h08 : 8'h02);
      repeat (2) begin
        wt(4 + t, 4100, n);
        ackp(4 + t);
      end
      wr(`MTP_ADDR_PBCTL, 8'h00);
      chkn(gap[4 + t], t ? `MTP_PRE_T3 * 10 : `MTP_PRE_T2 * 501, t ? `MTP_PRE_T3 * 10 : `MTP_PRE_T2 * 501);
      chk8(outs, 8'h00);
    end
    // pwm: formula on two, fixed rate on three
    wr(`MTP_ADDR_TH2, 8'h03); wr(`MTP_ADDR_TL2, 8'h40); wr(`MTP_ADDR_TH3, 8'h00); wr(`MTP_ADDR_TL3, 8'h80);
    wr(`MTP_ADDR_PBCTL, 8'h0F);
    repeat (6000) @(posedge i_ref_clk);
    chkn(gap[6], 256 * 4, 256 * 4);
    chkn(hi[6], 64 * 4, 64 * 4);
    chkn(gap[7], 256 * `MTP_FIX0_DIV, 256 * `MTP_FIX0_DIV);
    chkn(hi[7], 128 * `MTP_FIX0_DIV, 128 * `MTP_FIX0_DIV);
    wr(`MTP_ADDR_PBCTL, 8'h00);
    repeat (3) @(posedge i_ref_clk);
    #1 chk8(outs & 8'hC0, 8'h00);
    // reset in mid-run
    wr(`MTP_ADDR_PBCTL, 8'h0A);
    wr(`MTP_ADDR_TCTL, 8'h50);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    #1 chk8(outs, 8'h00);
    rdchk(`MTP_ADDR_PBCTL, 8'h00);
    stop_test();
  end
endmodule
